//--- verilog/wd_key_mux_pkg.sv
package wd_key_mux_pkg;
    // Register addresses within the serial frame
    localparam logic [4:0] ADDR_UNLOCK_KEY = 5'h0B;
    localparam logic [4:0] ADDR_PROBE_SEL = 5'h0C;
    localparam logic [4:0] ADDR_ST_MAIN = 5'h0D;
    localparam logic [4:0] ADDR_ST_SENSOR = 5'h0E;
    // Unlock key words
    localparam logic [7:0] KEY_WORD1 = 8'hD3;
    localparam logic [7:0] KEY_WORD2 = 8'h33;
    localparam logic [7:0] KEY_FLASH = 8'hCC;
    localparam logic [7:0] KEY_CONFIG = 8'hCD;
    localparam logic [7:0] KEY_RESTART = 8'hCE;
    localparam logic [7:0] KEY_DISABLE = 8'hCF;
    // Reset values
    localparam logic [3:0] PROBE_SEL_RST = 4'h0;
    localparam logic [7:0] ST_MAIN_RST = 8'h00;
    localparam logic [3:0] ST_SENSOR_RST = 4'h0;
    localparam logic [11:0] PROBE_ROUTE_RST = 12'h001;
    localparam logic [15:0] RESP_RST = 16'h0001;
    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 11;
    localparam int TYPE_POS = 10;
    localparam int DATA_MSB = 8;
    localparam int DATA_LSB = 1;
    localparam logic TYPE_WRITE = 1'b1;
    localparam logic PARITY_ODD = 1'b1;
    // Probe codes that route a signal; codes from here up route nothing
    localparam logic [3:0] PROBE_ROUTES = 4'hC;
    localparam logic [3:0] PROBE_TEMP = 4'h8;
    // Unlock sequence tracker
    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_GOT1 = 2'b01,
        KEY_GOT2 = 2'b10
    } key_state_t;
endpackage : wd_key_mux_pkg

//--- verilog/wd_key_mux_selftest_regs.sv
`timescale 1ns/1ns
module wd_key_mux_selftest_regs
    import wd_key_mux_pkg::*;
(
    // System clock, reset and enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // Serial link, host drives on rising edge, device samples on falling edge
    input wire logic spiClk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMisoOut,
    output logic spiMisoOe,
    // Self-test failure events from the analog checkers
    input wire logic [7:0] stFailMainIn,
    input wire logic [3:0] stFailSensorIn,
    // Watchdog key actions, one-cycle pulses
    output logic flashModeReq,
    output logic configModeReq,
    output logic wdRestartReq,
    output logic wdDisableReq,
    // Analog probe mux control
    output logic [3:0] probeSelect,
    output logic [11:0] probeRouteOh
);

    // Link side state
    logic linkIdle;
    logic [3:0] bitCnt_q;
    logic [14:0] rxShift_q;
    logic [15:0] rxFrame_q;
    logic rxTgl_q;

    // System side state
    logic rxTglS1_q, rxTglS2_q, rxTglS3_q;
    logic [7:0] stMainS1_q, stMainS2_q;
    logic [3:0] stSensorS1_q, stSensorS2_q;
    key_state_t keyState_q;
    logic [7:0] stMain_q;
    logic [3:0] stSensor_q;
    logic [15:0] respWord_q;

    // Decoded frame
    logic frameNew, parityOk, frameOk, frameWrite;
    logic [4:0] frameAddr;
    logic [7:0] frameData;
    logic keyWrite, probeWrite, mainWrite, sensorWrite;
    logic keyMatch;
    logic [7:0] rdData;
    logic [14:0] respBody;

    // Link logic is held idle between frames and during reset
    assign linkIdle = spiCsN | ~resetn;

    // Bit counter restarts with every chip select
    always_ff @(negedge spiClk or posedge linkIdle) begin
        if (linkIdle) begin
            bitCnt_q <= 4'h0;
        end else begin
            bitCnt_q <= bitCnt_q + 4'h1;
        end
    end

    // Shift in host bits and latch the complete frame on the sixteenth bit
    always_ff @(negedge spiClk or negedge resetn) begin
        if (!resetn) begin
            rxShift_q <= 15'h0000;
            rxFrame_q <= 16'h0000;
            rxTgl_q <= 1'b0;
        end else begin
            rxShift_q <= {rxShift_q[13:0], spiMosi};
            if (bitCnt_q == 4'hF) begin
                rxFrame_q <= {rxShift_q, spiMosi};
                rxTgl_q <= ~rxTgl_q;
            end
        end
    end

    // Answer word of the previous frame goes out MSB first; it is static during a frame
    always_ff @(posedge spiClk or posedge linkIdle) begin
        if (linkIdle) begin
            spiMisoOut <= 1'b0;
            spiMisoOe <= 1'b0;
        end else begin
            spiMisoOut <= respWord_q[~bitCnt_q];
            spiMisoOe <= 1'b1;
        end
    end

    // Frame toggle and self-test events cross into the system clock
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rxTglS1_q <= 1'b0;
            rxTglS2_q <= 1'b0;
            rxTglS3_q <= 1'b0;
            stMainS1_q <= 8'h00;
            stMainS2_q <= 8'h00;
            stSensorS1_q <= 4'h0;
            stSensorS2_q <= 4'h0;
        end else if (clkEn) begin
            rxTglS1_q <= rxTgl_q;
            rxTglS2_q <= rxTglS1_q;
            rxTglS3_q <= rxTglS2_q;
            stMainS1_q <= stFailMainIn;
            stMainS2_q <= stMainS1_q;
            stSensorS1_q <= stFailSensorIn;
            stSensorS2_q <= stSensorS1_q;
        end
    end

    // Frame decode; frames with wrong parity are dropped
    assign frameNew = clkEn & (rxTglS2_q ^ rxTglS3_q);
    assign parityOk = ((^rxFrame_q) == PARITY_ODD);
    assign frameOk = frameNew & parityOk;
    assign frameAddr = rxFrame_q[ADDR_MSB:ADDR_LSB];
    assign frameWrite = (rxFrame_q[TYPE_POS] == TYPE_WRITE);
    assign frameData = rxFrame_q[DATA_MSB:DATA_LSB];
    assign keyWrite = frameOk & frameWrite & (frameAddr == ADDR_UNLOCK_KEY);
    assign probeWrite = frameOk & frameWrite & (frameAddr == ADDR_PROBE_SEL);
    assign mainWrite = frameOk & frameWrite & (frameAddr == ADDR_ST_MAIN);
    assign sensorWrite = frameOk & frameWrite & (frameAddr == ADDR_ST_SENSOR);

    // Final key word is one of the four action codes
    assign keyMatch = (frameData == KEY_FLASH) | (frameData == KEY_CONFIG) |
                      (frameData == KEY_RESTART) | (frameData == KEY_DISABLE);

    // Unlock sequence tracker
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            keyState_q <= KEY_IDLE;
        end else if (keyWrite) begin
            case (keyState_q)
                KEY_IDLE: begin
                    keyState_q <= (frameData == KEY_WORD1) ? KEY_GOT1 : KEY_IDLE;
                end
                KEY_GOT1: begin
                    keyState_q <= (frameData == KEY_WORD2) ? KEY_GOT2 : KEY_IDLE;
                end
                KEY_GOT2: begin
                    keyState_q <= KEY_IDLE;
                end
                default: begin
                    keyState_q <= KEY_IDLE;
                end
            endcase
        end
    end

    // Action pulses on an accepted third word
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            flashModeReq <= 1'b0;
            configModeReq <= 1'b0;
            wdRestartReq <= 1'b0;
            wdDisableReq <= 1'b0;
        end else if (clkEn) begin
            flashModeReq <= keyWrite & (keyState_q == KEY_GOT2) & (frameData == KEY_FLASH);
            configModeReq <= keyWrite & (keyState_q == KEY_GOT2) & (frameData == KEY_CONFIG);
            wdRestartReq <= keyWrite & (keyState_q == KEY_GOT2) & (frameData == KEY_RESTART);
            wdDisableReq <= keyWrite & (keyState_q == KEY_GOT2) & (frameData == KEY_DISABLE);
        end
    end

    // Probe select and its one-hot route; codes 12 to 15 route nothing
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            probeSelect <= PROBE_SEL_RST;
            probeRouteOh <= PROBE_ROUTE_RST;
        end else if (probeWrite) begin
            probeSelect <= frameData[3:0];
            if (frameData[3:0] < PROBE_ROUTES) begin
                probeRouteOh <= 12'(12'h001 << frameData[3:0]);
            end else begin
                probeRouteOh <= 12'h000;
            end
        end
    end

    // Sticky failure flags; a new failure wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stMain_q <= ST_MAIN_RST;
            stSensor_q <= ST_SENSOR_RST;
        end else if (clkEn) begin
            stMain_q <= (stMain_q & ~(mainWrite ? frameData : 8'h00)) | stMainS2_q;
            stSensor_q <= (stSensor_q & ~(sensorWrite ? frameData[3:0] : 4'h0)) | stSensorS2_q;
        end
    end

    // Read data before any write of this frame; key register reads zero
    always_comb begin
        rdData = 8'h00;
        if (parityOk) begin
            case (frameAddr)
                ADDR_PROBE_SEL: rdData = {4'h0, probeSelect};
                ADDR_ST_MAIN: rdData = stMain_q;
                ADDR_ST_SENSOR: rdData = {4'h0, stSensor_q};
                default: rdData = 8'h00;
            endcase
        end
    end

    assign respBody = {frameAddr, rxFrame_q[TYPE_POS], 1'b0, rdData};

    // Answer word for the next frame, with odd parity
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            respWord_q <= RESP_RST;
        end else if (frameNew) begin
            respWord_q <= {respBody, ~(^respBody)};
        end
    end

    // Checks on the system clock
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    AST_KEY_ACTION: assert property (
        $rose(flashModeReq) |-> $past(keyWrite) && $past(keyState_q) == KEY_GOT2
            && $past(frameData) == KEY_FLASH)
        else $error("flash request without a full key sequence");

    AST_KEY_WORD2: assert property (
        keyWrite && keyState_q == KEY_GOT1 && frameData == KEY_WORD2 |=> keyState_q == KEY_GOT2)
        else $error("second key word not accepted");

    AST_KEY_MISMATCH: assert property (
        keyWrite && keyState_q == KEY_GOT1 && frameData != KEY_WORD2 |=> keyState_q == KEY_IDLE
            && !(flashModeReq || configModeReq || wdRestartReq || wdDisableReq))
        else $error("wrong key word did not drop progress");

    AST_KEY_RESTART: assert property (
        keyWrite && keyState_q == KEY_GOT2 && keyMatch
            |=> keyState_q == KEY_IDLE ##1 !(wdRestartReq || flashModeReq) [*2])
        else $error("tracker not back to first word after an action");

    AST_PROBE_ROUTE: assert property (
        probeSelect < PROBE_ROUTES |-> probeRouteOh == 12'(12'h001 << probeSelect))
        else $error("probe route does not match select");

    AST_PROBE_NONE: assert property (
        probeWrite && frameData[3:0] >= PROBE_ROUTES |=> probeRouteOh == 12'h000 && probeSelect[3])
        else $error("unused probe code routes a signal");

    AST_FLAG_SET: assert property (
        clkEn && stMainS2_q[7] |=> stMain_q[7])
        else $error("main failure event not recorded");

    AST_FLAG_STICKY: assert property (
        stSensor_q[0] && !(sensorWrite && frameData[0]) |=> stSensor_q[0])
        else $error("sensor flag cleared without a write of one");

    AST_FLAG_CLEAR: assert property (
        clkEn && mainWrite && frameData[0] && !stMainS2_q[0] |=> !stMain_q[0])
        else $error("write of one did not clear the flag");

    AST_SENSOR_UPPER: assert property (
        frameNew && parityOk && frameAddr == ADDR_ST_SENSOR |=> respWord_q[8:5] == 4'h0)
        else $error("sensor register upper bits not zero");

    // Tracker entry, pulse width, freezing and the idle link
    AST_KEY_WORD1: assert property (
        keyWrite && keyState_q == KEY_IDLE && frameData == KEY_WORD1 |=> keyState_q == KEY_GOT1)
        else $error("first key word not accepted");

    AST_KEY_FIRST: assert property (
        keyWrite && keyState_q == KEY_IDLE && frameData != KEY_WORD1 |=> keyState_q == KEY_IDLE)
        else $error("wrong first key word left progress");

    AST_PULSE_ONE: assert property (
        clkEn && (flashModeReq || configModeReq || wdRestartReq || wdDisableReq)
            |=> !(flashModeReq || configModeReq || wdRestartReq || wdDisableReq))
        else $error("action pulse longer than one cycle");

    AST_PROBE_HOLD: assert property (
        !probeWrite |=> $stable(probeSelect) && $stable(probeRouteOh))
        else $error("probe select changed without a write");

    AST_BAD_PARITY: assert property (
        frameNew && !parityOk |=> $stable(probeSelect) && $stable(keyState_q))
        else $error("frame with bad parity changed state");

    AST_SENSOR_SET: assert property (
        clkEn && stSensorS2_q[3] |=> stSensor_q[3])
        else $error("sensor failure event not recorded");

    AST_CLK_FREEZE: assert property (
        !clkEn |=> $stable(keyState_q) && $stable(probeSelect) && $stable(stMain_q) && $stable(stSensor_q))
        else $error("state moved while the clock enable was low");

    AST_ANSWER_PARITY: assert property (
        frameNew |=> (^respWord_q) == 1'b1)
        else $error("answer word without odd parity");

    AST_MISO_IDLE: assert property (
        spiCsN |-> !spiMisoOe && !spiMisoOut)
        else $error("data line driven while deselected");

    COV_FLASH: cover property (flashModeReq);
    COV_DISABLE: cover property (wdDisableReq);
    COV_TEMP: cover property (probeWrite && frameData[3:0] == PROBE_TEMP);
    COV_SET_WINS: cover property (mainWrite && (frameData & stMainS2_q) != 8'h00);
    COV_BAD_PARITY: cover property (frameNew && !parityOk);

endmodule : wd_key_mux_selftest_regs

//--- test/spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model (
    // Link pins toward the device
    output logic spiClk,
    output logic spiCsN,
    output logic spiMosi,
    // Link pin from the device
    input wire logic spiMisoOut
);
    // Clock parked low and select high outside frames
    initial begin
        spiClk = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end
    // One 16-bit frame, MSB first; data changes on rising edges, answer taken on falling edges
    task automatic xfer(input logic [15:0] w, output logic [15:0] ans);
        #17 spiCsN = 1'b0;
        #62;
        for (int i = 15; i >= 0; i--) begin
            spiClk = 1'b1;
            spiMosi = w[i];
            #62 spiClk = 1'b0;
            ans[i] = spiMisoOut;
            #63;
        end
        spiCsN = 1'b1;
        spiMosi = ~spiMosi; // No stale data bit between frames
        #400; // Select idle long enough for the answer to settle
    endtask : xfer
endmodule : spi_host_model

//--- test/test_wd_key_mux_selftest_regs.sv
`timescale 1ns/1ns
module test_wd_key_mux_selftest_regs;
    import wd_key_mux_pkg::*;
    logic ref_clk, resetn, clkEn, spiClk, spiCsN, spiMosi, spiMisoOut, spiMisoOe;
    logic flashModeReq, configModeReq, wdRestartReq, wdDisableReq;
    logic [7:0] stFailMainIn;
    logic [3:0] stFailSensorIn;
    logic [3:0] probeSelect;
    logic [11:0] probeRouteOh;
    logic [15:0] ans;
    logic [7:0] rdData;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    int pulseCnt[4] = '{default: 0};
    // Rows: {probe code, expected one-hot route}
    logic [15:0] probeRows[16] = '{16'h0001, 16'h1002, 16'h2004, 16'h3008, 16'h4010, 16'h5020, 16'h6040,
        16'h7080, 16'h8100, 16'h9200, 16'hA400, 16'hB800, 16'hC000, 16'hD000, 16'hE000, 16'hF000};

    wd_key_mux_selftest_regs dut (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .spiClk(spiClk),
        .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe),
        .stFailMainIn(stFailMainIn), .stFailSensorIn(stFailSensorIn), .flashModeReq(flashModeReq),
        .configModeReq(configModeReq), .wdRestartReq(wdRestartReq), .wdDisableReq(wdDisableReq),
        .probeSelect(probeSelect), .probeRouteOh(probeRouteOh));
    spi_host_model host (.spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMisoOut(spiMisoOut));

    // System clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Hang guard and action pulse counters
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
        if (flashModeReq === 1'b1) pulseCnt[0]++;
        if (configModeReq === 1'b1) pulseCnt[1]++;
        if (wdRestartReq === 1'b1) pulseCnt[2]++;
        if (wdDisableReq === 1'b1) pulseCnt[3]++;
    end
    // Drive enable stands through every bit of a frame
    always @(negedge spiClk) begin
        if (resetn === 1'b1) check({15'h0000, spiMisoOe}, {15'h0000, ~spiCsN});
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Frame with odd parity over all 16 bits
    function automatic logic [15:0] frame(input logic [4:0] a, input logic t, input logic [7:0] d);
        frame = {a, t, 1'b0, d, 1'b0};
        frame[0] = ~^frame[15:1];
    endfunction : frame
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.xfer(frame(a, TYPE_WRITE, d), ans);
    endtask : wr
    // Answer arrives one frame late, so read twice
    task automatic rd(input logic [4:0] a);
        host.xfer(frame(a, 1'b0, 8'h00), ans);
        host.xfer(frame(a, 1'b0, 8'h00), ans);
        rdData = ans[8:1];
    endtask : rd
    // Three key frames, then the four pulse counts packed one nibble each
    task automatic keyseq(input logic [7:0] w1, input logic [7:0] w2, input logic [7:0] w3,
        input logic [15:0] exp);
        int base[4];
        logic [15:0] got;
        base = pulseCnt;
        wr(ADDR_UNLOCK_KEY, w1);
        wr(ADDR_UNLOCK_KEY, w2);
        wr(ADDR_UNLOCK_KEY, w3);
        for (int i = 0; i < 4; i++) got[4 * i +: 4] = 4'(pulseCnt[i] - base[i]);
        check(got, exp);
    endtask : keyseq
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        resetn = 1'b0;
        clkEn = 1'b1;
        stFailMainIn = 8'h00;
        stFailSensorIn = 4'h0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check({probeSelect, probeRouteOh}, 16'h0001);
        check({15'h0000, spiMisoOe}, 16'h0000);
        host.xfer(frame(ADDR_ST_MAIN, 1'b0, 8'h00), ans);
        check(ans, 16'h0001);
        rd(ADDR_ST_MAIN);
        check({8'h00, rdData}, 16'h0000);
        $display("Test reset done");
        // Every probe code, upper data bits set and ignored
        foreach (probeRows[k]) begin
            wr(ADDR_PROBE_SEL, {4'h5, probeRows[k][15:12]});
            check({probeSelect, probeRouteOh}, probeRows[k]);
        end
        rd(ADDR_PROBE_SEL);
        check({8'h00, rdData}, 16'h000F);
        host.xfer(frame(ADDR_PROBE_SEL, TYPE_WRITE, 8'h02) ^ 16'h0001, ans);
        check({12'h000, probeSelect}, 16'h000F);
        $display("Test probe done");
        // Each action back to back, then broken and stale sequences
        for (int a = 0; a < 4; a++) keyseq(KEY_WORD1, KEY_WORD2, 8'(KEY_FLASH + a), 16'h0001 << (4 * a));
        keyseq(KEY_WORD2, KEY_RESTART, KEY_RESTART, 16'h0000);
        keyseq(KEY_WORD1, 8'h5A, KEY_WORD2, 16'h0000);
        keyseq(KEY_RESTART, KEY_WORD1, KEY_WORD2, 16'h0000);
        keyseq(KEY_DISABLE, KEY_WORD1, KEY_WORD1, 16'h1000);
        $display("Test key done");
        // Failure events are sticky and cleared by writing ones
        stFailMainIn <= 8'hA5;
        stFailSensorIn <= 4'h9;
        repeat (4) @(posedge ref_clk);
        stFailMainIn <= 8'h00;
        stFailSensorIn <= 4'h0;
        rd(ADDR_ST_MAIN);
        check({8'h00, rdData}, 16'h00A5);
        rd(ADDR_ST_SENSOR);
        check({8'h00, rdData}, 16'h0009);
        wr(ADDR_ST_MAIN, 8'h00);
        wr(ADDR_ST_MAIN, 8'h05);
        wr(ADDR_ST_SENSOR, 8'hF1);
        rd(ADDR_ST_MAIN);
        check({8'h00, rdData}, 16'h00A0);
        rd(ADDR_ST_SENSOR);
        check({8'h00, rdData}, 16'h0008);
        $display("Test flags done");
        // Reset in mid-run
        wr(ADDR_PROBE_SEL, 8'h07);
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({probeSelect, probeRouteOh}, 16'h0001);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(ADDR_ST_SENSOR);
        check({8'h00, rdData}, 16'h0000);
        $display("Test second reset done");
        // Clock enable low: a frame waits and an event never reaches the flags
        @(posedge ref_clk);
        clkEn <= 1'b0;
        stFailSensorIn <= 4'h2;
        wr(ADDR_PROBE_SEL, 8'h03);
        @(posedge ref_clk);
        stFailSensorIn <= 4'h0;
        clkEn <= 1'b1;
        check({probeSelect, probeRouteOh}, 16'h0001);
        repeat (6) @(posedge ref_clk);
        check({probeSelect, probeRouteOh}, 16'h3008);
        rd(ADDR_ST_SENSOR);
        check({8'h00, rdData}, 16'h0000);
        $display("Test clock enable done");
        finish_test();
    end
endmodule : test_wd_key_mux_selftest_regs
